// ---- rtl/rse_params.svh ----
`ifndef RSE_PARAMS_SVH
`define RSE_PARAMS_SVH
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define RSE_DATA_W      8
`define RSE_WDOG_W      8
`define RSE_PRE_W       8
`define RSE_WDOG_CLEAR  8'h00
`define RSE_PRE_CLEAR   8'h00
`define RSE_BYTE_ZERO   8'h00
`define RSE_NIB_W       4
`define RSE_MSB         7
`define RSE_LSB         0
`define RSE_POWER_DOWN_RESET 1'b1
`define RSE_EXPIRY_RESET     1'b1
`define RSE_DEST_W      1'b0
`define RSE_DEST_F      1'b1
`endif

// ---- rtl/rse_pkg.sv ----
package rse_pkg;
   // ----------------------------------------
   // Operation codes issued by the decoder
   // ----------------------------------------
   typedef enum logic [2:0] {
      RSE_OP_NONE,
      RSE_OP_ROTATE_LEFT_VIA_CARRY,
      RSE_OP_ROTATE_RIGHT_VIA_CARRY,
      RSE_OP_LITERAL_MINUS_WORKING,
      RSE_OP_SLEEP
   } rse_op_t;

   typedef enum logic {
      RSE_RUN,
      RSE_ASLEEP
   } rse_state_t;
endpackage : rse_pkg

// ---- rtl/rse_alu_if.sv ----
`timescale 1ns/1ps
`include "rse_params.svh"
// ----------------------------------------
// Operand and result carrier to the arithmetic unit
// ----------------------------------------
interface rse_alu_if;
   import rse_pkg::*;
   rse_op_t                  op;
   logic [`RSE_DATA_W-1:0]   file_val;
   logic [`RSE_DATA_W-1:0]   work_val;
   logic [`RSE_DATA_W-1:0]   literal;
   logic                     carry_in;
   logic [`RSE_DATA_W-1:0]   result;
   logic                     carry_out;
   logic                     digit_carry;
   logic                     zero;
   modport core (output op, file_val, work_val, literal, carry_in,
                 input result, carry_out, digit_carry, zero);
   modport alu  (input op, file_val, work_val, literal, carry_in,
                 output result, carry_out, digit_carry, zero);
endinterface : rse_alu_if

// ---- rtl/rse_alu.sv ----
`timescale 1ns/1ps
`include "rse_params.svh"
module rse_alu
   import rse_pkg::*;
(
   rse_alu_if.alu alu
);
   // ----------------------------------------
   // Combinational rotate and subtract datapath
   // ----------------------------------------
   logic [`RSE_DATA_W-1:0] diff;

   // Subtraction is k - W; carry is the no-borrow flag.
   always_comb begin
      diff            = alu.literal - alu.work_val;                     // [RULE8]
      alu.result      = alu.file_val;
      alu.carry_out   = alu.carry_in;
      alu.digit_carry = 1'b0;
      alu.zero        = 1'b0;
      unique case (alu.op)
         RSE_OP_ROTATE_LEFT_VIA_CARRY: begin
            alu.result    = {alu.file_val[`RSE_MSB-1:`RSE_LSB], alu.carry_in}; // [RULE1]
            alu.carry_out = alu.file_val[`RSE_MSB];                           // [RULE1]
         end
         RSE_OP_ROTATE_RIGHT_VIA_CARRY: begin
            alu.result    = {alu.carry_in, alu.file_val[`RSE_MSB:`RSE_LSB+1]}; // [RULE3]
            alu.carry_out = alu.file_val[`RSE_LSB];                           // [RULE3]
         end
         RSE_OP_LITERAL_MINUS_WORKING: begin
            alu.result      = diff;
            alu.carry_out   = (alu.work_val <= alu.literal);                 // [RULE10]
            alu.digit_carry = (alu.work_val[`RSE_NIB_W-1:0]
                               <= alu.literal[`RSE_NIB_W-1:0]);              // [RULE10]
            alu.zero        = (diff == `RSE_BYTE_ZERO);                      // [RULE10]
         end
         default: begin
         end
      endcase
   end
endmodule : rse_alu

// ---- rtl/rse_core.sv ----
// Contract
// [RULE1] Rotate left: old carry into bit 0, old bit 7 becomes carry.
// [RULE2] Destination bit 0 writes working register; 1 writes the file register.
// [RULE3] Rotate right: old carry into bit 7, old bit 0 becomes carry.
// [RULE4] Sleep clears the power-down flag.
// [RULE5] Sleep sets the watchdog expiry flag.
// [RULE6] Sleep clears the watchdog counter and its prescaler.
// [RULE7] After sleep the core stops and the oscillator is halted.
// [RULE8] Literal subtract computes literal minus working register, eight bits.
// [RULE9] Literal subtract result goes only to the working register.
// [RULE10] Carry and digit carry set when W not above k; zero on zero.
// [RULE11] Rotates take one cycle and change only the carry flag.
`timescale 1ns/1ps
`include "rse_params.svh"
module rse_core
   import rse_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   input  wire logic                   issue_valid,
   input  wire rse_op_t                issue_op,
   input  wire logic                   dest_sel,
   input  wire logic [`RSE_DATA_W-1:0] file_rd_data,
   input  wire logic [`RSE_DATA_W-1:0] literal,
   input  wire logic                   wake,
   input  wire logic                   watchdog_tick,
   output logic                        issue_ready,
   output logic                        file_wr_en,
   output logic [`RSE_DATA_W-1:0]      file_wr_data,
   output logic [`RSE_DATA_W-1:0]      working_reg,
   output logic                        carry_flag,
   output logic                        digit_carry_flag,
   output logic                        zero_flag,
   output logic                        power_down_flag,
   output logic                        watchdog_expiry_flag,
   output logic [`RSE_WDOG_W-1:0]      watchdog_counter,
   output logic                        osc_run
);
   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      rse_state_t               state;
      logic                     fwe;
      logic [`RSE_DATA_W-1:0]   fwd;
      logic [`RSE_DATA_W-1:0]   w;
      logic                     c;
      logic                     dig;
      logic                     z;
      logic                     pwr_down;
      logic                     expiry;
      logic [`RSE_WDOG_W-1:0]   wdog;
      logic [`RSE_PRE_W-1:0]    pre;
   } rse_core_state_t;

   rse_core_state_t s_q;
   rse_core_state_t s_d;
   logic            go;

   rse_alu_if alu_bus ();

   // ----------------------------------------
   // Arithmetic unit
   // ----------------------------------------
   rse_alu u_alu (
      .alu (alu_bus.alu)
   );

   // File and literal operands come straight from the ports, W and carry from the state record, so each op finishes in one cycle.
   assign alu_bus.op       = issue_op;
   assign alu_bus.file_val = file_rd_data;
   assign alu_bus.work_val = s_q.w;
   assign alu_bus.literal  = literal;
   assign alu_bus.carry_in = s_q.c;

   // Nothing is taken while asleep, since the oscillator is stopped.
   assign issue_ready = (s_q.state == RSE_RUN);                          // [RULE7]
   assign go          = issue_valid && issue_ready;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d     = s_q;
      s_d.fwe = 1'b0;
      // The prescaler feeds the counter; a carry out of it advances the counter.
      if (watchdog_tick) begin
         s_d.pre = s_q.pre + 1'b1;
         if (&s_q.pre) begin
            s_d.wdog = s_q.wdog + 1'b1;
         end
      end
      unique case (s_q.state)
         RSE_RUN: begin
            if (go) begin
               unique case (issue_op)
                  RSE_OP_ROTATE_LEFT_VIA_CARRY,
                  RSE_OP_ROTATE_RIGHT_VIA_CARRY: begin
                     s_d.c = alu_bus.carry_out;                          // [RULE11]
                     if (dest_sel == `RSE_DEST_F) begin
                        s_d.fwe = 1'b1;                                  // [RULE2]
                        s_d.fwd = alu_bus.result;
                     end else begin
                        s_d.w = alu_bus.result;                          // [RULE2]
                     end
                  end
                  RSE_OP_LITERAL_MINUS_WORKING: begin
                     s_d.w  = alu_bus.result;                            // [RULE9]
                     s_d.c  = alu_bus.carry_out;                         // [RULE10]
                     s_d.dig = alu_bus.digit_carry;                      // [RULE10]
                     s_d.z  = alu_bus.zero;
                  end
                  RSE_OP_SLEEP: begin
                     s_d.pwr_down = 1'b0;                                // [RULE4]
                     s_d.expiry   = 1'b1;                                // [RULE5]
                     s_d.wdog     = `RSE_WDOG_CLEAR;                     // [RULE6]
                     s_d.pre   = `RSE_PRE_CLEAR;                         // [RULE6]
                     s_d.state = RSE_ASLEEP;                             // [RULE7]
                  end
                  default: begin
                  end
               endcase
            end
         end
         RSE_ASLEEP: begin
            // Wake-up is owned by the surrounding core; this block only resumes.
            if (wake) begin
               s_d.state = RSE_RUN;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_q       <= '0;
         s_q.state <= RSE_RUN;
         s_q.pwr_down <= `RSE_POWER_DOWN_RESET;
         s_q.expiry   <= `RSE_EXPIRY_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign file_wr_en           = s_q.fwe;
   assign file_wr_data         = s_q.fwd;
   assign working_reg          = s_q.w;
   assign carry_flag           = s_q.c;
   assign digit_carry_flag     = s_q.dig;
   assign zero_flag            = s_q.z;
   assign power_down_flag      = s_q.pwr_down;
   assign watchdog_expiry_flag = s_q.expiry;
   assign watchdog_counter     = s_q.wdog;
   assign osc_run              = (s_q.state == RSE_RUN);                 // [RULE7]

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence rot_issue;
      go && (issue_op == RSE_OP_ROTATE_LEFT_VIA_CARRY
             || issue_op == RSE_OP_ROTATE_RIGHT_VIA_CARRY);
   endsequence

   sequence sleep_issue;
      go && issue_op == RSE_OP_SLEEP;
   endsequence

   sequence sub_issue;
      go && issue_op == RSE_OP_LITERAL_MINUS_WORKING;
   endsequence

   chk_rotl_value: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE1]
      go && issue_op == RSE_OP_ROTATE_LEFT_VIA_CARRY && dest_sel == `RSE_DEST_W
      |=> working_reg == {$past(file_rd_data[`RSE_MSB-1:`RSE_LSB]), $past(carry_flag)}
          && carry_flag == $past(file_rd_data[`RSE_MSB]))
      else $error("rotate left result wrong");
   chk_rotr_value: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
      go && issue_op == RSE_OP_ROTATE_RIGHT_VIA_CARRY && dest_sel == `RSE_DEST_F
      |=> file_wr_data == {$past(carry_flag), $past(file_rd_data[`RSE_MSB:`RSE_LSB+1])}
          && carry_flag == $past(file_rd_data[`RSE_LSB]))
      else $error("rotate right result wrong");
   chk_rot_dest: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2]
      rot_issue |=> file_wr_en == $past(dest_sel))
      else $error("rotate destination wrong");
   chk_rot_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE11]
      rot_issue |=> $stable(digit_carry_flag) && $stable(zero_flag))
      else $error("rotate touched other flags");
   chk_sleep_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
      go && issue_op == RSE_OP_SLEEP |=> !power_down_flag && watchdog_expiry_flag)
      else $error("sleep flags wrong");
   chk_sleep_watchdog: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
      sleep_issue |=> watchdog_counter == `RSE_WDOG_CLEAR)
      else $error("sleep did not clear watchdog");
   chk_sleep_halt: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE7]
      sleep_issue ##1 !wake |=> !osc_run && !issue_ready)
      else $error("core still running after sleep");
   chk_sub_value: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
      go && issue_op == RSE_OP_LITERAL_MINUS_WORKING
      |=> working_reg == $past(literal) - $past(working_reg) && !file_wr_en
          && carry_flag == ($past(working_reg) <= $past(literal)))
      else $error("literal subtract wrong");

   // Side effects that the value checks above leave open, plus the expiry flag again; the prescaler is internal.
   chk_sleep_expiry: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE5]
      sleep_issue |=> watchdog_expiry_flag)
      else $error("sleep left expiry flag clear");
   chk_sleep_prescale: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
      sleep_issue |=> s_q.pre == `RSE_PRE_CLEAR)
      else $error("sleep did not clear prescaler");
   chk_sub_flags: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
      sub_issue
      |=> digit_carry_flag == ($past(working_reg[`RSE_NIB_W-1:0])
                               <= $past(literal[`RSE_NIB_W-1:0]))
          && zero_flag == ($past(literal) == $past(working_reg)))
      else $error("literal subtract flags wrong");
   chk_rot_status: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE11]
      rot_issue |=> $stable(power_down_flag) && $stable(watchdog_expiry_flag))
      else $error("rotate touched power flags");
   chk_asleep_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE7]
      !issue_ready && !wake
      |=> !issue_ready && !file_wr_en && $stable(working_reg) && $stable(carry_flag))
      else $error("core changed state while asleep");
   chk_file_write: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2] [RULE9]
      file_wr_en |-> $past(go) && $past(dest_sel) == `RSE_DEST_F
                     && $past(issue_op) != RSE_OP_LITERAL_MINUS_WORKING
                     && $past(issue_op) != RSE_OP_SLEEP)
      else $error("file write without a rotate to the file");
endmodule : rse_core

// ---- tb/rse_file_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Register file stand-in: the one addressed byte
// ----------------------------------------
module rse_file_model (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       load_en,
   input  wire logic [7:0] load_val,
   input  wire logic       file_wr_en,
   input  wire logic [7:0] file_wr_data,
   output logic      [7:0] file_rd_data
);
   logic [7:0] mem_q;

   // The bypass offers a fresh operand in the issue cycle itself.
   assign file_rd_data = load_en ? load_val : mem_q;

   // A core write-back wins over a preset, as a real file would.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mem_q <= 8'h00;
      end else if (file_wr_en) begin
         mem_q <= file_wr_data;
      end else if (load_en) begin
         mem_q <= load_val;
      end
   end
endmodule : rse_file_model

// ---- tb/rotate_subtract_sleep_execution_tb.sv ----
`timescale 1ns/1ps
`include "rse_params.svh"
module rotate_subtract_sleep_execution_tb;
   import rse_pkg::*;
   logic       sys_clk, resetn, issue_valid, dest_sel, wake, watchdog_tick, load_en;
   rse_op_t    issue_op;
   logic [7:0] literal, load_val, file_rd_data, file_wr_data, working_reg, watchdog_counter;
   logic       issue_ready, file_wr_en, carry_flag, digit_carry_flag, zero_flag;
   logic       power_down_flag, watchdog_expiry_flag, osc_run, exp_c;
   logic [7:0] exp_w, exp_f;
   int         errors, samples_checked;

   rse_core dut_u (.sys_clk(sys_clk), .resetn(resetn), .issue_valid(issue_valid),
      .issue_op(issue_op), .dest_sel(dest_sel), .file_rd_data(file_rd_data),
      .literal(literal), .wake(wake), .watchdog_tick(watchdog_tick), .issue_ready(issue_ready),
      .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .working_reg(working_reg),
      .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
      .power_down_flag(power_down_flag), .watchdog_expiry_flag(watchdog_expiry_flag),
      .watchdog_counter(watchdog_counter), .osc_run(osc_run));

   rse_file_model file_u (.sys_clk(sys_clk), .resetn(resetn), .load_en(load_en),
      .load_val(load_val), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
      .file_rd_data(file_rd_data));

   // Free-running 25 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One issue cycle; returns at the next falling edge with results settled.
   task automatic issue(input rse_op_t op, input logic d, input logic ld,
                        input logic [7:0] f, input logic [7:0] k);
      @(negedge sys_clk);
      issue_valid = 1'b1;
      issue_op = op;
      dest_sel = d;
      load_en = ld;
      load_val = f;
      literal = k;
      @(negedge sys_clk);
      issue_valid = 1'b0;
      load_en = 1'b0;
   endtask : issue

   task automatic rot(input logic left, input logic d, input logic ld, input logic [7:0] f);
      logic [7:0] r;
      logic       z_prev;
      logic       dig_prev;
      if (!ld) f = exp_f;
      r = left ? {f[6:0], exp_c} : {exp_c, f[7:1]};
      z_prev = zero_flag;
      dig_prev = digit_carry_flag;
      issue(left ? RSE_OP_ROTATE_LEFT_VIA_CARRY : RSE_OP_ROTATE_RIGHT_VIA_CARRY, d, ld, f, 8'h00);
      exp_c = left ? f[7] : f[0];
      if (ld) exp_f = f;
      if (d) exp_f = r;
      else exp_w = r;
      chk(8'(file_wr_en), 8'(d));
      chk(d ? file_wr_data : working_reg, r);
      chk(working_reg, exp_w);
      chk(8'(carry_flag), 8'(exp_c));
      chk({6'h00, zero_flag, digit_carry_flag}, {6'h00, z_prev, dig_prev});
   endtask : rot

   // Destination bit is set on purpose: the result must still land in W.
   task automatic sub(input logic [7:0] k);
      logic [7:0] r;
      r = k - exp_w;
      issue(RSE_OP_LITERAL_MINUS_WORKING, 1'b1, 1'b0, 8'h00, k);
      chk(working_reg, r);
      chk(8'(file_wr_en), 8'h00);
      chk({5'h00, carry_flag, digit_carry_flag, zero_flag},
          {5'h00, exp_w <= k, exp_w[3:0] <= k[3:0], r == 8'h00});
      exp_c = (exp_w <= k);
      exp_w = r;
   endtask : sub

   task automatic ticks(input int n);
      watchdog_tick = 1'b1;
      repeat (n) @(negedge sys_clk);
      watchdog_tick = 1'b0;
   endtask : ticks

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_sub;
      logic [7:0] ks [5] = '{8'h00, 8'hFF, 8'h0F, 8'h10, 8'h37};
      foreach (ks[i]) sub(ks[i]);
      $display("test literal subtract done");
   endtask : test_sub

   task automatic test_rotate;
      rot(1'b1, 1'b1, 1'b1, 8'hE6);
      rot(1'b1, 1'b0, 1'b0, 8'h00);
      rot(1'b0, 1'b0, 1'b1, 8'h01);
      rot(1'b0, 1'b1, 1'b1, 8'h80);
      rot(1'b0, 1'b1, 1'b0, 8'h00);
      $display("test rotate done");
   endtask : test_rotate

   // Ticks before sleep leave the prescaler part-way, so a missed clear shows later.
   task automatic test_sleep;
      chk({6'h00, power_down_flag, watchdog_expiry_flag}, 8'h03);
      @(negedge sys_clk);
      ticks(300);
      issue(RSE_OP_SLEEP, 1'b0, 1'b0, 8'h00, 8'h00);
      chk(8'(power_down_flag), 8'h00);
      chk(8'(watchdog_expiry_flag), 8'h01);
      chk(watchdog_counter, 8'h00);
      chk({6'h00, osc_run, issue_ready}, 8'h00);
      issue(RSE_OP_ROTATE_LEFT_VIA_CARRY, 1'b1, 1'b1, 8'hFF, 8'h00);
      chk({6'h00, file_wr_en, carry_flag}, {6'h00, 1'b0, exp_c});
      wake = 1'b1;
      @(negedge sys_clk);
      wake = 1'b0;
      chk({6'h00, osc_run, issue_ready}, 8'h03);
      ticks(255);
      chk(watchdog_counter, 8'h00);
      ticks(1);
      chk(watchdog_counter, 8'h01);
      $display("test sleep done");
   endtask : test_sleep

   // A reset taken while asleep must bring back the power-on state and W of zero.
   task automatic test_reset;
      issue(RSE_OP_SLEEP, 1'b0, 1'b0, 8'h00, 8'h00);
      resetn = 1'b0;
      @(negedge sys_clk);
      chk({6'h00, power_down_flag, watchdog_expiry_flag}, 8'h03);
      chk({6'h00, osc_run, issue_ready}, 8'h03);
      resetn = 1'b1;
      exp_w = 8'h00;
      sub(8'h81);
      issue(RSE_OP_SLEEP, 1'b0, 1'b0, 8'h00, 8'h00);
      chk({6'h00, power_down_flag, osc_run}, 8'h00);
      wake = 1'b1;
      @(negedge sys_clk);
      wake = 1'b0;
      $display("test mid-run reset done");
   endtask : test_reset

   task automatic complete_run;
      $display("Counts: %0d compared, %0d mismatched", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   // Bound on the whole run; running out counts as a mismatch.
   initial begin
      #2000000;
      errors++;
      complete_run();
   end

   // Main sequence: reset for five cycles, then each scenario in turn.
   initial begin
      {resetn, issue_valid, dest_sel, wake, watchdog_tick, load_en} = 6'h00;
      issue_op = RSE_OP_NONE;
      literal = 8'h00;
      load_val = 8'h00;
      {errors, samples_checked} = 0;
      {exp_w, exp_f, exp_c} = 17'h0_0000;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      test_sub();
      test_rotate();
      test_sleep();
      test_reset();
      complete_run();
   end
endmodule : rotate_subtract_sleep_execution_tb
